// *** logic/ppfs_map.svh ***
`ifndef PPFS_MAP_SVH
`define PPFS_MAP_SVH
// Operation
// - pin7 bits15:14 pick port/timer B/chip select 3
// - pin6 bits13:12 pick port/timer A/chip select 2
// - pin5 bits11:10 pick port/serial1 clock/DMA/interrupt
// - bit8 makes pin4 serial1 transmit output
// - bit6 feeds pin3 into serial1 receive
// - pin2 bits5:4 pick port/serial0 clock/DMA/interrupt
// - bit2 makes pin1 serial0 transmit output
// - bit0 feeds pin0 into serial0 receive
// - reserved control bits read zero, write zero
// - first-note fields reset one in expansion modes
// - second-note fields reset one in expansion modes with ROM disabled
// - high bit14 makes pin23 top-byte write strobe
// - high bit12 makes pin22 upper-middle write strobe
// - high bit10 makes pin21 chip select 5
// - high bit8 makes pin20 chip select 4
// - pin19 field bits7:6 picks port/bus grant/DMA ack1
// - port pins follow direction bits, reset input
// - control registers are 16-bit read/write words

// ==========================================================
// Register byte addresses
`define PPFS_ADDR_HIGH 32'h0000_0000
`define PPFS_ADDR_LOW1 32'h0000_0004
`define PPFS_ADDR_LOW2 32'h0000_0008
`define PPFS_ADDR_DIR_HIGH 32'h0000_000c
`define PPFS_ADDR_DIR_LOW 32'h0000_0010

// ==========================================================
// Writable masks; reserved bits stay zero
`define PPFS_MASK_HIGH 16'h55f7
`define PPFS_MASK_LOW1 16'h555f
`define PPFS_MASK_LOW2 16'hfd75
`define PPFS_MASK_DIR_HIGH 16'h00ff
`define PPFS_MASK_DIR_LOW 16'hffff

// ==========================================================
// Reset values and mode-dependent reset bits
`define PPFS_RST_ZERO 16'h0000
`define PPFS_RST_NOTE1_LOW1 16'h4000
`define PPFS_RST_NOTE2_LOW1 16'h1550
`define PPFS_RST_NOTE2_HIGH 16'h5000

// ==========================================================
// Field positions
`define PPFS_P7_MSB 15
`define PPFS_P7_LSB 14
`define PPFS_P6_MSB 13
`define PPFS_P6_LSB 12
`define PPFS_P5_MSB 11
`define PPFS_P5_LSB 10
`define PPFS_P4_BIT 8
`define PPFS_P3_BIT 6
`define PPFS_P2_MSB 5
`define PPFS_P2_LSB 4
`define PPFS_P1_BIT 2
`define PPFS_P0_BIT 0
`define PPFS_P23_BIT 14
`define PPFS_P22_BIT 12
`define PPFS_P21_BIT 10
`define PPFS_P20_BIT 8
`define PPFS_P19_MSB 7
`define PPFS_P19_LSB 6

// ==========================================================
// Function codes and bus answers
`define PPFS_SEL_PORT 2'h0
`define PPFS_SEL_A 2'h1
`define PPFS_SEL_B 2'h2
`define PPFS_SEL_C 2'h3
`define PPFS_RESP_OKAY 2'h0
`define PPFS_RESP_SLVERR 2'h2
`define PPFS_IN_IDLE 1'h1
`endif

// *** logic/ppfs_pkg.sv ***
package ppfs_pkg;
    // Control word as seen by software
    typedef logic [15:0] ppfs_reg_type;
    // Write channel progress
    typedef enum {PPFS_W_COLLECT, PPFS_W_RESP} ppfs_wstate_type;
endpackage

// *** logic/ppfs_pin_cell.sv ***
`include "ppfs_map.svh"
module ppfs_pin_cell (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Function side
    input wire logic func_en,
    input wire logic func_o,
    input wire logic func_oe,
    // Port side
    input wire logic port_dir,
    input wire logic port_o,
    // Pad
    output logic pad_o,
    output logic pad_oe
);
    // Peripheral owns the pad when selected, else the port direction bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pad_o <= 1'b0;
            pad_oe <= 1'b0;
        end else if (func_en) begin
            pad_o <= func_o;
            pad_oe <= func_oe;
        end else begin
            pad_o <= port_o;
            pad_oe <= port_dir;
        end
    end
endmodule

// *** logic/ppfs_top.sv ***
`include "ppfs_map.svh"
module ppfs_top (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Boot mode straps
    input wire logic ext_expansion_mode,
    input wire logic rom_disabled,
    // AXI4-Lite write address
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pads
    input wire logic [23:0] pad_i,
    output logic [23:0] pad_o,
    output logic [23:0] pad_oe,
    // Port data block
    input wire logic [23:0] port_out_data,
    output logic [23:0] port_in_data,
    // Peripheral outputs toward the pads
    input wire logic chip_select_2_out,
    input wire logic chip_select_3_out,
    input wire logic chip_select_4_out,
    input wire logic chip_select_5_out,
    input wire logic write_strobe_top_byte,
    input wire logic write_strobe_upper_mid_byte,
    input wire logic bus_grant_ack,
    input wire logic dma_acknowledge_1,
    input wire logic serial0_transmit,
    input wire logic serial1_transmit,
    input wire logic serial0_clock_o,
    input wire logic serial0_clock_oe,
    input wire logic serial1_clock_o,
    input wire logic serial1_clock_oe,
    // Pad inputs toward the peripherals
    output logic timer_ext_clock_a,
    output logic timer_ext_clock_b,
    output logic serial0_clock_i,
    output logic serial1_clock_i,
    output logic serial0_receive,
    output logic serial1_receive,
    output logic dma_request_0,
    output logic dma_request_1,
    output logic ext_interrupt_0,
    output logic ext_interrupt_1
);
    // ==========================================================
    // Register state
    ppfs_pkg::ppfs_reg_type high_q, low1_q, low2_q, dir_high_q, dir_low_q;
    ppfs_pkg::ppfs_wstate_type wstate_q;
    logic aw_held_q, w_held_q, awready_q, wready_q, bvalid_q, rvalid_q, arready_q;
    logic [31:0] awaddr_q, wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic [15:0] wmask, wnew;
    logic [1:0] f7, f6, f5, f2, f19;
    logic [23:0] fn_en, fn_o, fn_oe, dir_all;
    logic do_write;

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // ==========================================================
    // Write channel: address and data latched in either order
    assign do_write = aw_held_q && w_held_q && (wstate_q == ppfs_pkg::PPFS_W_COLLECT);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            awaddr_q <= 32'h0000_0000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            wstate_q <= ppfs_pkg::PPFS_W_COLLECT;
            bvalid_q <= 1'b0;
            bresp_q <= `PPFS_RESP_OKAY;
        end else begin
            // Ready is registered but masked by the handshake, so it drops on the transfer edge itself
            awready_q <= !aw_held_q && !(s_axi_awvalid && awready_q) && !do_write
                && (wstate_q == ppfs_pkg::PPFS_W_COLLECT);
            wready_q <= !w_held_q && !(s_axi_wvalid && wready_q) && !do_write
                && (wstate_q == ppfs_pkg::PPFS_W_COLLECT);
            if (s_axi_awvalid && awready_q) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_q) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            case (wstate_q)
                ppfs_pkg::PPFS_W_COLLECT: begin
                    if (do_write) begin
                        aw_held_q <= 1'b0;
                        w_held_q <= 1'b0;
                        bvalid_q <= 1'b1;
                        bresp_q <= (wmask == 16'h0000) ? `PPFS_RESP_SLVERR : `PPFS_RESP_OKAY;
                        wstate_q <= ppfs_pkg::PPFS_W_RESP;
                    end
                end
                ppfs_pkg::PPFS_W_RESP: begin
                    if (s_axi_bready) begin
                        bvalid_q <= 1'b0;
                        wstate_q <= ppfs_pkg::PPFS_W_COLLECT;
                    end
                end
                default: wstate_q <= ppfs_pkg::PPFS_W_COLLECT;
            endcase
        end
    end

    // Writable mask of the addressed word; zero means unmapped
    always_comb begin
        if ({awaddr_q[31:2], 2'h0} == `PPFS_ADDR_HIGH) begin
            wmask = `PPFS_MASK_HIGH;
        end else if ({awaddr_q[31:2], 2'h0} == `PPFS_ADDR_LOW1) begin
            wmask = `PPFS_MASK_LOW1;
        end else if ({awaddr_q[31:2], 2'h0} == `PPFS_ADDR_LOW2) begin
            wmask = `PPFS_MASK_LOW2;
        end else if ({awaddr_q[31:2], 2'h0} == `PPFS_ADDR_DIR_HIGH) begin
            wmask = `PPFS_MASK_DIR_HIGH;
        end else if ({awaddr_q[31:2], 2'h0} == `PPFS_ADDR_DIR_LOW) begin
            wmask = `PPFS_MASK_DIR_LOW;
        end else begin
            wmask = 16'h0000;
        end
    end

    // Byte lanes 0 and 1 only; upper lanes carry nothing
    assign wnew = {wstrb_q[1] ? wdata_q[15:8] : 8'h00, wstrb_q[0] ? wdata_q[7:0] : 8'h00};

    // Merge one register, keeping unstrobed lanes and clearing reserved bits
    function automatic ppfs_pkg::ppfs_reg_type merge(input ppfs_pkg::ppfs_reg_type old,
                                                     input logic [15:0] mask);
        logic [15:0] lanes;
        lanes = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
        merge = ((old & ~lanes) | (wnew & lanes)) & mask;
    endfunction

    // ==========================================================
    // Control registers; straps decide some reset values
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            low2_q <= `PPFS_RST_ZERO;
            dir_high_q <= `PPFS_RST_ZERO;
            dir_low_q <= `PPFS_RST_ZERO;
            // Sync reset, so the straps are sampled while it is held
            low1_q <= (ext_expansion_mode ? `PPFS_RST_NOTE1_LOW1 : `PPFS_RST_ZERO)
                | ((ext_expansion_mode && rom_disabled) ? `PPFS_RST_NOTE2_LOW1
                   : `PPFS_RST_ZERO);
            high_q <= (ext_expansion_mode && rom_disabled) ? `PPFS_RST_NOTE2_HIGH
                : `PPFS_RST_ZERO;
        end else if (do_write) begin
            if (wmask == `PPFS_MASK_HIGH) begin
                high_q <= merge(high_q, `PPFS_MASK_HIGH);
            end else if (wmask == `PPFS_MASK_LOW1) begin
                low1_q <= merge(low1_q, `PPFS_MASK_LOW1);
            end else if (wmask == `PPFS_MASK_LOW2) begin
                low2_q <= merge(low2_q, `PPFS_MASK_LOW2);
            end else if (wmask == `PPFS_MASK_DIR_HIGH) begin
                dir_high_q <= merge(dir_high_q, `PPFS_MASK_DIR_HIGH);
            end else if (wmask == `PPFS_MASK_DIR_LOW) begin
                dir_low_q <= merge(dir_low_q, `PPFS_MASK_DIR_LOW);
            end
        end
    end

    // ==========================================================
    // Read channel; answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `PPFS_RESP_OKAY;
        end else if (rvalid_q) begin
            if (s_axi_rready) begin
                rvalid_q <= 1'b0;
                arready_q <= 1'b1;
            end
        end else if (s_axi_arvalid) begin
            rvalid_q <= 1'b1;
            arready_q <= 1'b0;
            rresp_q <= `PPFS_RESP_OKAY;
            // Reserved bits are never stored, so they read zero
            if ({s_axi_araddr[31:2], 2'h0} == `PPFS_ADDR_HIGH) begin
                rdata_q <= {16'h0000, high_q};
            end else if ({s_axi_araddr[31:2], 2'h0} == `PPFS_ADDR_LOW1) begin
                rdata_q <= {16'h0000, low1_q};
            end else if ({s_axi_araddr[31:2], 2'h0} == `PPFS_ADDR_LOW2) begin
                rdata_q <= {16'h0000, low2_q};
            end else if ({s_axi_araddr[31:2], 2'h0} == `PPFS_ADDR_DIR_HIGH) begin
                rdata_q <= {16'h0000, dir_high_q};
            end else if ({s_axi_araddr[31:2], 2'h0} == `PPFS_ADDR_DIR_LOW) begin
                rdata_q <= {16'h0000, dir_low_q};
            end else begin
                rdata_q <= 32'h0000_0000;
                rresp_q <= `PPFS_RESP_SLVERR;
            end
        end
    end

    // ==========================================================
    // Function decode per pin
    assign f7 = low2_q[`PPFS_P7_MSB:`PPFS_P7_LSB];
    assign f6 = low2_q[`PPFS_P6_MSB:`PPFS_P6_LSB];
    assign f5 = low2_q[`PPFS_P5_MSB:`PPFS_P5_LSB];
    assign f2 = low2_q[`PPFS_P2_MSB:`PPFS_P2_LSB];
    assign f19 = high_q[`PPFS_P19_MSB:`PPFS_P19_LSB];
    assign dir_all = {dir_high_q[7:0], dir_low_q};

    // Input functions and prohibited codes leave the pad undriven by peripherals
    always_comb begin
        fn_en = 24'h00_0000;
        fn_o = 24'h00_0000;
        fn_oe = 24'h00_0000;
        fn_en[7] = (f7 == `PPFS_SEL_A) || (f7 == `PPFS_SEL_B);
        fn_o[7] = chip_select_3_out;
        fn_oe[7] = (f7 == `PPFS_SEL_B);
        fn_en[6] = (f6 == `PPFS_SEL_A) || (f6 == `PPFS_SEL_B);
        fn_o[6] = chip_select_2_out;
        fn_oe[6] = (f6 == `PPFS_SEL_B);
        fn_en[5] = (f5 != `PPFS_SEL_PORT);
        fn_o[5] = serial1_clock_o;
        fn_oe[5] = (f5 == `PPFS_SEL_A) && serial1_clock_oe;
        fn_en[4] = low2_q[`PPFS_P4_BIT];
        fn_o[4] = serial1_transmit;
        fn_oe[4] = 1'b1;
        fn_en[3] = low2_q[`PPFS_P3_BIT];
        fn_en[2] = (f2 != `PPFS_SEL_PORT);
        fn_o[2] = serial0_clock_o;
        fn_oe[2] = (f2 == `PPFS_SEL_A) && serial0_clock_oe;
        fn_en[1] = low2_q[`PPFS_P1_BIT];
        fn_o[1] = serial0_transmit;
        fn_oe[1] = 1'b1;
        fn_en[0] = low2_q[`PPFS_P0_BIT];
        fn_en[23] = high_q[`PPFS_P23_BIT];
        fn_o[23] = write_strobe_top_byte;
        fn_oe[23] = 1'b1;
        fn_en[22] = high_q[`PPFS_P22_BIT];
        fn_o[22] = write_strobe_upper_mid_byte;
        fn_oe[22] = 1'b1;
        fn_en[21] = high_q[`PPFS_P21_BIT];
        fn_o[21] = chip_select_5_out;
        fn_oe[21] = 1'b1;
        fn_en[20] = high_q[`PPFS_P20_BIT];
        fn_o[20] = chip_select_4_out;
        fn_oe[20] = 1'b1;
        fn_en[19] = (f19 == `PPFS_SEL_A) || (f19 == `PPFS_SEL_B);
        fn_o[19] = (f19 == `PPFS_SEL_A) ? bus_grant_ack : dma_acknowledge_1;
        fn_oe[19] = 1'b1;
    end

    // One registered cell per pad
    for (genvar i = 0; i < 24; i++) begin : g_pin
        ppfs_pin_cell u_cell (
            .aclk(aclk),
            .aresetn(aresetn),
            .func_en(fn_en[i]),
            .func_o(fn_o[i]),
            .func_oe(fn_oe[i]),
            .port_dir(dir_all[i]),
            .port_o(port_out_data[i]),
            .pad_o(pad_o[i]),
            .pad_oe(pad_oe[i])
        );
    end

    // ==========================================================
    // Pad inputs toward peripherals; idle level when not routed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_in_data <= 24'h00_0000;
            timer_ext_clock_a <= `PPFS_IN_IDLE;
            timer_ext_clock_b <= `PPFS_IN_IDLE;
            serial0_clock_i <= `PPFS_IN_IDLE;
            serial1_clock_i <= `PPFS_IN_IDLE;
            serial0_receive <= `PPFS_IN_IDLE;
            serial1_receive <= `PPFS_IN_IDLE;
            dma_request_0 <= `PPFS_IN_IDLE;
            dma_request_1 <= `PPFS_IN_IDLE;
            ext_interrupt_0 <= `PPFS_IN_IDLE;
            ext_interrupt_1 <= `PPFS_IN_IDLE;
        end else begin
            port_in_data <= pad_i;
            timer_ext_clock_b <= (f7 == `PPFS_SEL_A) ? pad_i[7] : `PPFS_IN_IDLE;
            timer_ext_clock_a <= (f6 == `PPFS_SEL_A) ? pad_i[6] : `PPFS_IN_IDLE;
            serial1_clock_i <= (f5 == `PPFS_SEL_A) ? pad_i[5] : `PPFS_IN_IDLE;
            dma_request_1 <= (f5 == `PPFS_SEL_B) ? pad_i[5] : `PPFS_IN_IDLE;
            ext_interrupt_1 <= (f5 == `PPFS_SEL_C) ? pad_i[5] : `PPFS_IN_IDLE;
            serial1_receive <= low2_q[`PPFS_P3_BIT] ? pad_i[3] : `PPFS_IN_IDLE;
            serial0_clock_i <= (f2 == `PPFS_SEL_A) ? pad_i[2] : `PPFS_IN_IDLE;
            dma_request_0 <= (f2 == `PPFS_SEL_B) ? pad_i[2] : `PPFS_IN_IDLE;
            ext_interrupt_0 <= (f2 == `PPFS_SEL_C) ? pad_i[2] : `PPFS_IN_IDLE;
            serial0_receive <= low2_q[`PPFS_P0_BIT] ? pad_i[0] : `PPFS_IN_IDLE;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_p7_cs_route;
        (f7 == `PPFS_SEL_B) |=> pad_oe[7] && (pad_o[7] == $past(chip_select_3_out));
    endproperty
    a_p7_cs_route: assert property (p_p7_cs_route) else $error("pin7 chip select wrong");

    property p_p6_timer_route;
        (f6 == `PPFS_SEL_A) |=> !pad_oe[6] && (timer_ext_clock_a == $past(pad_i[6]));
    endproperty
    a_p6_timer_route: assert property (p_p6_timer_route) else $error("pin6 timer clock wrong");

    property p_p5_irq_route;
        (f5 == `PPFS_SEL_C) |=> !pad_oe[5] && (ext_interrupt_1 == $past(pad_i[5]))
            && dma_request_1;
    endproperty
    a_p5_irq_route: assert property (p_p5_irq_route) else $error("pin5 interrupt wrong");

    property p_p4_tx_route;
        low2_q[`PPFS_P4_BIT] |=> pad_oe[4] && (pad_o[4] == $past(serial1_transmit));
    endproperty
    a_p4_tx_route: assert property (p_p4_tx_route) else $error("pin4 transmit wrong");

    property p_p2_clk_route;
        (f2 == `PPFS_SEL_A) |=> (pad_oe[2] == $past(serial0_clock_oe))
            && (serial0_clock_i == $past(pad_i[2]));
    endproperty
    a_p2_clk_route: assert property (p_p2_clk_route) else $error("pin2 serial clock wrong");

    property p_reserved_zero;
        ((high_q & ~`PPFS_MASK_HIGH) == 16'h0000) && ((low1_q & ~`PPFS_MASK_LOW1) == 16'h0000)
            && ((low2_q & ~`PPFS_MASK_LOW2) == 16'h0000);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    property p_prohibited_port;
        (f19 == `PPFS_SEL_C) |=> (pad_oe[19] == $past(dir_all[19]))
            && (pad_o[19] == $past(port_out_data[19]));
    endproperty
    a_prohibited_port: assert property (p_prohibited_port) else $error("pin19 not port");

    property p_port_dir;
        (!fn_en[21] && !dir_all[21]) |=> !pad_oe[21];
    endproperty
    a_port_dir: assert property (p_port_dir) else $error("pin21 port input driven");

    property p_strap_reset;
        $rose(aresetn) |-> (low1_q[14] == $past(ext_expansion_mode))
            && (high_q[14] == $past(ext_expansion_mode && rom_disabled));
    endproperty
    a_strap_reset: assert property (@(posedge aclk) p_strap_reset)
        else $error("strap reset value wrong");

    property p_write_resp;
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_write_resp: assert property (p_write_resp) else $error("write answer dropped");

    property p_bresp_timing;
        do_write |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready;
    endproperty
    a_bresp_timing: assert property (p_bresp_timing) else $error("write answer late");

    c_p7_cs: cover property (f7 == `PPFS_SEL_B ##1 pad_oe[7]);
    c_p2_irq: cover property (f2 == `PPFS_SEL_C ##1 !ext_interrupt_0);
    c_write: cover property (do_write ##1 s_axi_bvalid && s_axi_bready);
    c_read_err: cover property (s_axi_rvalid && (s_axi_rresp == `PPFS_RESP_SLVERR));
endmodule

// *** sim/ppfs_periph_model.sv ***
// ==========================================================
// Peripherals and external pads around the pin multiplexer
module ppfs_periph_model (
    // Level chosen by the bench for peripherals and idle pads
    input wire logic lvl,
    // Pads
    input wire logic [23:0] pad_o,
    input wire logic [23:0] pad_oe,
    output logic [23:0] pad_i,
    // Peripheral outputs, serial clock enables in the top two bits
    output logic [13:0] periph_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Undriven pads take the bench level so a stale value never passes
    assign pad_i = (pad_o & pad_oe) | ({24{lvl}} & ~pad_oe);
    // Serial clock enables held high so clock-mode pins are driven
    assign periph_o = {2'b11, {12{lvl}}};
endmodule

// *** sim/tb_top.sv ***
`include "ppfs_map.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Stimulus and observed signals
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic ext_mode = 1'b1;
    logic rom_off = 1'b1;
    logic lvl = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] rdata;
    logic [1:0] bresp, rresp;
    logic [23:0] pad_i, pad_o, pad_oe, port_in;
    logic [13:0] po;
    logic [9:0] pin_in;
    int n_errors = 0, checks_done = 0, cyc = 0;
    // 25 MHz clock
    always #20 aclk = ~aclk;
    // ==========================================================
    // Design and partner
    ppfs_top dut (
        .aclk(aclk), .aresetn(aresetn), .ext_expansion_mode(ext_mode), .rom_disabled(rom_off),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pad_i(pad_i), .pad_o(pad_o), .pad_oe(pad_oe),
        .port_out_data(24'hffffff), .port_in_data(port_in),
        .chip_select_2_out(po[0]), .chip_select_3_out(po[1]), .chip_select_4_out(po[2]),
        .chip_select_5_out(po[3]), .write_strobe_top_byte(po[4]),
        .write_strobe_upper_mid_byte(po[5]), .bus_grant_ack(po[6]), .dma_acknowledge_1(po[7]),
        .serial0_transmit(po[8]), .serial1_transmit(po[9]), .serial0_clock_o(po[10]),
        .serial1_clock_o(po[11]), .serial0_clock_oe(po[12]), .serial1_clock_oe(po[13]),
        .timer_ext_clock_a(pin_in[9]), .timer_ext_clock_b(pin_in[8]),
        .serial0_clock_i(pin_in[7]), .serial1_clock_i(pin_in[6]), .serial0_receive(pin_in[5]),
        .serial1_receive(pin_in[4]), .dma_request_0(pin_in[3]), .dma_request_1(pin_in[2]),
        .ext_interrupt_0(pin_in[1]), .ext_interrupt_1(pin_in[0])
    );
    ppfs_periph_model peer (.lvl(lvl), .pad_o(pad_o), .pad_oe(pad_oe), .pad_i(pad_i),
        .periph_o(po));
    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Straps must be stable across the whole reset hold
    task automatic rst(input logic e, input logic r);
        @(posedge aclk);
        aresetn <= 1'b0;
        ext_mode <= e;
        rom_off <= r;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [31:0] a, input logic [15:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk(32'(bresp), 32'(er));
    endtask
    task automatic rd(input logic [31:0] a, input logic [15:0] e, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk(rdata, {16'h0000, e});
        chk(32'(rresp), 32'(er));
    endtask
    // Kind k: 0 port output, 1 peripheral output, 2 input; ein is the routed input pattern
    task automatic pin(input logic hi, input logic [15:0] v, input int p, input int k,
                       input logic [9:0] ein);
        wr(hi ? `PPFS_ADDR_HIGH : `PPFS_ADDR_LOW2, v, `PPFS_RESP_OKAY);
        for (int l = 0; l < 2; l++) begin
            lvl <= l[0];
            repeat (3) @(posedge aclk);
            chk(32'({pad_oe[p], pad_oe[p] & pad_o[p]}),
                32'(k == 0 ? 2'b11 : (k == 1 ? {1'b1, l[0]} : 2'b00)));
            chk(32'(pin_in), 32'(l[0] ? 10'h3ff : ein));
            chk(32'(port_in[p]), 32'(k == 0 ? 1'b1 : l[0]));
        end
    endtask
    // Watchdog far above the expected run length
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            results();
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        rst(1'b1, 1'b1);
        rd(`PPFS_ADDR_HIGH, 16'h5000, `PPFS_RESP_OKAY);
        rd(`PPFS_ADDR_LOW1, 16'h5550, `PPFS_RESP_OKAY);
        rd(`PPFS_ADDR_LOW2, 16'h0000, `PPFS_RESP_OKAY);
        rst(1'b1, 1'b0);
        rd(`PPFS_ADDR_HIGH, 16'h0000, `PPFS_RESP_OKAY);
        rd(`PPFS_ADDR_LOW1, 16'h4000, `PPFS_RESP_OKAY);
        rst(1'b0, 1'b0);
        rd(`PPFS_ADDR_LOW1, 16'h0000, `PPFS_RESP_OKAY);
        // Reserved bits are written as ones on purpose to prove they never stick
        wr(`PPFS_ADDR_HIGH, 16'hffff, `PPFS_RESP_OKAY);
        rd(`PPFS_ADDR_HIGH, 16'h55f7, `PPFS_RESP_OKAY);
        wr(`PPFS_ADDR_LOW1, 16'hffff, `PPFS_RESP_OKAY);
        rd(`PPFS_ADDR_LOW1, 16'h555f, `PPFS_RESP_OKAY);
        wr(`PPFS_ADDR_LOW2, 16'hffff, `PPFS_RESP_OKAY);
        rd(`PPFS_ADDR_LOW2, 16'hfd75, `PPFS_RESP_OKAY);
        wr(`PPFS_ADDR_DIR_HIGH, 16'hffff, `PPFS_RESP_OKAY);
        rd(`PPFS_ADDR_DIR_HIGH, 16'h00ff, `PPFS_RESP_OKAY);
        wr(`PPFS_ADDR_DIR_LOW, 16'hffff, `PPFS_RESP_OKAY);
        wr(32'h0000_0014, 16'hffff, `PPFS_RESP_SLVERR);
        rd(32'h0000_0014, 16'h0000, `PPFS_RESP_SLVERR);
        // Every code of pin7; every non-port code of the other low pin fields
        pin(1'b0, 16'h0000, 7, 0, 10'h3ff);
        pin(1'b0, 16'h4000, 7, 2, 10'h2ff);
        pin(1'b0, 16'h8000, 7, 1, 10'h3ff);
        pin(1'b0, 16'hc000, 7, 0, 10'h3ff);
        pin(1'b0, 16'h1000, 6, 2, 10'h1ff);
        pin(1'b0, 16'h2000, 6, 1, 10'h3ff);
        pin(1'b0, 16'h3000, 6, 0, 10'h3ff);
        pin(1'b0, 16'h0400, 5, 1, 10'h3bf);
        pin(1'b0, 16'h0800, 5, 2, 10'h3fb);
        pin(1'b0, 16'h0c00, 5, 2, 10'h3fe);
        pin(1'b0, 16'h0100, 4, 1, 10'h3ff);
        pin(1'b0, 16'h0040, 3, 2, 10'h3ef);
        pin(1'b0, 16'h0010, 2, 1, 10'h37f);
        pin(1'b0, 16'h0020, 2, 2, 10'h3f7);
        pin(1'b0, 16'h0030, 2, 2, 10'h3fd);
        pin(1'b0, 16'h0004, 1, 1, 10'h3ff);
        pin(1'b0, 16'h0001, 0, 2, 10'h3df);
        // High pins, with the low register back to plain port
        wr(`PPFS_ADDR_LOW2, 16'h0000, `PPFS_RESP_OKAY);
        pin(1'b1, 16'h4000, 23, 1, 10'h3ff);
        pin(1'b1, 16'h1000, 22, 1, 10'h3ff);
        pin(1'b1, 16'h0400, 21, 1, 10'h3ff);
        pin(1'b1, 16'h0100, 20, 1, 10'h3ff);
        pin(1'b1, 16'h0040, 19, 1, 10'h3ff);
        pin(1'b1, 16'h0080, 19, 1, 10'h3ff);
        pin(1'b1, 16'h00c0, 19, 0, 10'h3ff);
        // Port pins turn to inputs when the direction bits clear
        wr(`PPFS_ADDR_DIR_LOW, 16'h0000, `PPFS_RESP_OKAY);
        pin(1'b0, 16'h0000, 3, 2, 10'h3ff);
        results();
    end
endmodule
